// *** src/ccp_pkg.sv ***
package ccp_pkg;

  // APB map: printed offsets 3 and 4 are indices, byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned INDEX_REG_IDX = 3;
  localparam int unsigned DATA_REG_IDX = 4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_INDEX = 12'(4 * INDEX_REG_IDX);
  localparam logic [ADDR_W-1:0] ADDR_DATA = 12'(4 * DATA_REG_IDX);
  localparam logic [ADDR_W-1:0] ADDR_LINE_VOL = 12'h014;

  // Control indirect space
  localparam int unsigned CIND_COUNT = 9;
  localparam logic [3:0] CIND_ID = 4'h1;
  localparam logic [3:0] CIND_PINMUX = 4'h8;
  localparam logic [3:0] CIND_LAST = 4'h8;
  localparam int unsigned C8_WT_BIT = 0;
  localparam int unsigned C8_DSP_BIT = 1;
  localparam logic [7:0] CIND_RESET = 8'h00;

  // Global configuration byte fields
  localparam int unsigned GCFG_SUPPRESS_BIT = 0;
  localparam int unsigned GCFG_WT_BIT = 1;
  localparam int unsigned GCFG_DSP_BIT = 2;
  localparam int unsigned GCFG_VF_LO_BIT = 3;
  localparam int unsigned GCFG_VF_HI_BIT = 4;
  localparam int unsigned GCFG_DECOUPLE_BIT = 5;
  localparam logic [7:0] GCFG_RESET = 8'h00;

  // Hardware configuration byte positions and code base values
  localparam logic [7:0] HWCFG_GLOBAL_IDX = 8'h02;
  localparam logic [7:0] HWCFG_CODE_BASE_IDX = 8'h09;
  localparam logic [7:0] CODE_BASE_CURRENT = 8'h0b;
  localparam logic [7:0] CODE_BASE_LEGACY = 8'h43;

  localparam logic [7:0] LINE_VOL_RESET = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    VF_BUTTON_LOW,
    VF_BUTTON_HIGH,
    VF_STEP_DIR,
    VF_QUADRATURE
  } ccp_vol_fmt_t;

  typedef enum {LD_WAIT, LD_READ, LD_DONE} ccp_load_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } ccp_apb_req_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } ccp_pins8_t;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } ccp_ser4_t;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } ccp_ser3_t;

endpackage

// *** src/ccp_sync.sv ***
`timescale 1ns/1ns
module ccp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import ccp_pkg::*;

  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (reset) begin
          meta_q[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // ccp_sync

// *** src/ccp_pin_mux.sv ***
`timescale 1ns/1ns
module ccp_pin_mux (
  input wire logic clk,
  input wire logic reset,
  input wire logic wt_route,
  input wire logic dsp_route,
  input ccp_pkg::ccp_pins8_t periph_drv,
  input ccp_pkg::ccp_ser3_t wt_drv,
  input ccp_pkg::ccp_ser4_t dsp_drv,
  input wire logic [7:0] xd_sync,
  input wire logic [3:0] js2_sync,
  output ccp_pkg::ccp_pins8_t xd_drv,
  output ccp_pkg::ccp_ser4_t js2_drv,
  output logic [2:0] wt_rx,
  output logic [3:0] dsp_rx
);
  import ccp_pkg::*;

  ccp_pins8_t xd_d;
  ccp_ser4_t js2_d;

  // Upper data pins carry the wavetable port, lower ones the DSP port, else peripheral data
  assign xd_d.o = {wt_route ? wt_drv.o : periph_drv.o[7:5],
                   dsp_route ? dsp_drv.o : periph_drv.o[4:1], periph_drv.o[0]};
  assign xd_d.oe = {wt_route ? wt_drv.oe : periph_drv.oe[7:5],
                    dsp_route ? dsp_drv.oe : periph_drv.oe[4:1], periph_drv.oe[0]};
  // Joystick pins go back to plain inputs when the DSP port moves away
  assign js2_d.o = dsp_route ? 4'h0 : dsp_drv.o;
  assign js2_d.oe = dsp_route ? 4'h0 : dsp_drv.oe;

  always_ff @(posedge clk) begin
    if (reset) begin
      xd_drv <= '0;
      js2_drv <= '0;
      wt_rx <= 3'h0;
      dsp_rx <= 4'h0;
    end else begin
      xd_drv <= xd_d;
      js2_drv <= js2_d;
      wt_rx <= wt_route ? xd_sync[7:5] : 3'h0;
      dsp_rx <= dsp_route ? xd_sync[4:1] : js2_sync;
    end
  end
endmodule // ccp_pin_mux

// *** src/ccp_control.sv ***
// Notes on behaviour
// - Index register at offset 3, data port at offset 4 reaches indirect 0..8.
// - Suppress bit stops every peripheral read from driving the ISA data bus.
// - Wavetable enable in indirect 8 or global byte routes wavetable to upper pins.
// - DSP pin select in indirect 8 or global byte moves DSP port to lower pins.
// - Two format bits choose one of four hardware volume pin formats.
// - Decouple bit blocks legacy synthesis volume writes from changing line volume.
// - Firmware loads only when code base byte 9 is 0x0b; 0x43 skips firmware.
// - Chip id reads from indirect 1 and codec extended id output.
`timescale 1ns/1ns
module ccp_control #(
  parameter logic [7:0] CHIP_ID = 8'h5a
) (
  input wire logic clk,
  input wire logic reset,
  input ccp_pkg::ccp_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ee_valid,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_data,
  input wire logic ee_last,
  output logic fw_load_en,
  output logic fw_ignore,
  output logic cfg_loaded,
  input wire logic isa_periph_rd,
  output logic isa_periph_drive_en,
  input wire logic [7:0] xd_in,
  input ccp_pkg::ccp_pins8_t periph_drv,
  output ccp_pkg::ccp_pins8_t xd_drv,
  input wire logic [3:0] js2_in,
  output ccp_pkg::ccp_ser4_t js2_drv,
  input ccp_pkg::ccp_ser4_t dsp_drv,
  output logic [3:0] dsp_rx,
  input ccp_pkg::ccp_ser3_t wt_drv,
  output logic [2:0] wt_rx,
  input wire logic [1:0] vol_pins,
  output logic vol_up,
  output logic vol_down,
  input wire logic synth_vol_wr,
  input wire logic [7:0] synth_vol_data,
  output logic [7:0] line_volume,
  output logic [7:0] ext_id
);
  import ccp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [3:0] index_q;
  logic [7:0] cind_q [CIND_COUNT];
  logic [7:0] gcfg_q;
  logic [7:0] line_vol_q;
  logic [31:0] prdata_q;
  logic [7:0] code_base_q;
  ccp_load_state_t load_q;
  logic fw_load_q;
  logic fw_ignore_q;

  wire setup = apb_req.psel & ~apb_req.penable;
  wire access = apb_req.psel & apb_req.penable;
  wire hit_status = apb_req.paddr == ADDR_STATUS;
  wire hit_index = apb_req.paddr == ADDR_INDEX;
  wire hit_data = apb_req.paddr == ADDR_DATA;
  wire hit_line = apb_req.paddr == ADDR_LINE_VOL;
  wire hit_any = hit_status | hit_index | hit_data | hit_line;
  wire wr_access = access & apb_req.pwrite;
  // Indices past the last slot read as zero and swallow writes
  wire index_valid = index_q <= CIND_LAST;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;
  assign prdata = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Indirect control space

  // Read value of one indirect slot; the id slot is fixed and never stored
  // id slot read
  function automatic logic [7:0] cind_read(input logic [3:0] idx, input logic [7:0] stored);
    if (idx == CIND_ID) begin
      return CHIP_ID;
    end
    return stored;
  endfunction

  wire [7:0] data_port_rd = index_valid ? cind_read(index_q, cind_q[index_q]) : 8'h00;
  wire data_port_wr = wr_access & hit_data & index_valid & (index_q != CIND_ID);

  always_ff @(posedge clk) begin
    if (reset) begin
      index_q <= 4'h0;
    end else if (wr_access & hit_index) begin
      index_q <= apb_req.pwdata[3:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CIND_COUNT; gi++) begin : g_cind
      always_ff @(posedge clk) begin
        if (reset) begin
          cind_q[gi] <= CIND_RESET;
        end else if (data_port_wr && index_q == 4'(gi)) begin
          cind_q[gi] <= apb_req.pwdata[7:0];
        end
      end
    end
  endgenerate

  assign ext_id = CHIP_ID;

  //////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle

  wire [31:0] status_word = {21'h0, fw_ignore_q, fw_load_q,
                             load_q == LD_DONE, gcfg_q};
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_index ? {28'h0, index_q} :
                       hit_data ? {24'h0, data_port_rd} :
                       hit_line ? {24'h0, line_vol_q} : RDATA_ZERO;

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_q <= RDATA_ZERO;
    end else if (setup) begin
      prdata_q <= apb_req.pwrite ? RDATA_ZERO : rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hardware configuration loader

  // Bytes of the stream outside the two watched positions pass by untouched
  always_ff @(posedge clk) begin
    if (reset) begin
      load_q <= LD_WAIT;
      gcfg_q <= GCFG_RESET;
      code_base_q <= 8'h00;
      fw_load_q <= 1'b0;
      fw_ignore_q <= 1'b0;
    end else begin
      case (load_q)
        LD_WAIT, LD_READ: begin
          if (ee_valid) begin
            load_q <= ee_last ? LD_DONE : LD_READ;
            if (ee_addr == HWCFG_GLOBAL_IDX) begin
              gcfg_q <= ee_data;
            end
            if (ee_addr == HWCFG_CODE_BASE_IDX) begin
              code_base_q <= ee_data;
            end
          end
        end
        LD_DONE: begin
          fw_load_q <= code_base_q == CODE_BASE_CURRENT;
          fw_ignore_q <= code_base_q != CODE_BASE_CURRENT;
        end
        default: begin
          load_q <= LD_WAIT;
        end
      endcase
    end
  end

  assign fw_load_en = fw_load_q;
  assign fw_ignore = fw_ignore_q;
  assign cfg_loaded = load_q == LD_DONE;

  //////////////////////////////////////////////////////////////////////////////
  // Peripheral read suppression and pin routing

  wire suppress = gcfg_q[GCFG_SUPPRESS_BIT];
  assign isa_periph_drive_en = isa_periph_rd & ~suppress;

  wire wt_route = cind_q[CIND_PINMUX][C8_WT_BIT] | gcfg_q[GCFG_WT_BIT];
  wire dsp_route = cind_q[CIND_PINMUX][C8_DSP_BIT] | gcfg_q[GCFG_DSP_BIT];

  logic [7:0] xd_sync;
  logic [3:0] js2_sync;
  logic [1:0] vol_sync;

  ccp_sync #(.W(14)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({vol_pins, js2_in, xd_in}),
    .q({vol_sync, js2_sync, xd_sync})
  );

  ccp_pin_mux u_mux (
    .clk(clk),
    .reset(reset),
    .wt_route(wt_route),
    .dsp_route(dsp_route),
    .periph_drv(periph_drv),
    .wt_drv(wt_drv),
    .dsp_drv(dsp_drv),
    .xd_sync(xd_sync),
    .js2_sync(js2_sync),
    .xd_drv(xd_drv),
    .js2_drv(js2_drv),
    .wt_rx(wt_rx),
    .dsp_rx(dsp_rx)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Hardware volume pins

  logic [1:0] vol_prev_q;
  logic vol_up_q;
  logic vol_down_q;
  // Synchroniser reads low in reset; a pin idling high would otherwise look like an edge
  logic [2:0] vol_arm_q;

  wire [1:0] vf_bits = {gcfg_q[GCFG_VF_HI_BIT], gcfg_q[GCFG_VF_LO_BIT]};
  wire ccp_vol_fmt_t vol_fmt = ccp_vol_fmt_t'(vf_bits);
  wire [1:0] rise = vol_sync & ~vol_prev_q;
  wire [1:0] fall = ~vol_sync & vol_prev_q;
  wire quad_step = vol_sync[0] ^ vol_prev_q[0];
  wire vol_armed = vol_arm_q[2];
  logic up_d;
  logic down_d;

  always_comb begin
    up_d = 1'b0;
    down_d = 1'b0;
    case (vol_fmt)
      VF_BUTTON_LOW: begin
        up_d = fall[0];
        down_d = fall[1];
      end
      VF_BUTTON_HIGH: begin
        up_d = rise[0];
        down_d = rise[1];
      end
      VF_STEP_DIR: begin
        up_d = rise[0] & vol_sync[1];
        down_d = rise[0] & ~vol_sync[1];
      end
      VF_QUADRATURE: begin
        up_d = quad_step & (vol_sync[0] ^ vol_sync[1]);
        down_d = quad_step & ~(vol_sync[0] ^ vol_sync[1]);
      end
      default: begin
        up_d = 1'b0;
        down_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      vol_prev_q <= 2'h0;
      vol_arm_q <= 3'h0;
      vol_up_q <= 1'b0;
      vol_down_q <= 1'b0;
    end else begin
      vol_prev_q <= vol_sync;
      vol_arm_q <= {vol_arm_q[1:0], 1'b1};
      vol_up_q <= up_d & vol_armed;
      vol_down_q <= down_d & vol_armed;
    end
  end

  assign vol_up = vol_up_q;
  assign vol_down = vol_down_q;

  //////////////////////////////////////////////////////////////////////////////
  // Line input volume

  wire synth_takes = synth_vol_wr & ~gcfg_q[GCFG_DECOUPLE_BIT];

  // Host write wins over a synthesis write in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      line_vol_q <= LINE_VOL_RESET;
    end else if (wr_access & hit_line) begin
      line_vol_q <= apb_req.pwdata[7:0];
    end else if (synth_takes) begin
      line_vol_q <= synth_vol_data;
    end
  end

  assign line_volume = line_vol_q;
endmodule // ccp_control

// *** verif/ccp_props.sv ***
`timescale 1ns/1ns
module ccp_props #(
  parameter logic [7:0] CHIP_ID = 8'h5a
) (
  input wire logic clk,
  input wire logic reset,
  input ccp_pkg::ccp_apb_req_t apb_req,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ee_valid,
  input wire logic ee_last,
  input wire logic fw_load_en,
  input wire logic fw_ignore,
  input wire logic cfg_loaded,
  input wire logic isa_periph_rd,
  input wire logic isa_periph_drive_en,
  input ccp_pkg::ccp_pins8_t periph_drv,
  input ccp_pkg::ccp_pins8_t xd_drv,
  input wire logic [7:0] ext_id
);
  import ccp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire acc = apb_req.psel & apb_req.penable;
  wire mapped = apb_req.paddr inside {ADDR_STATUS, ADDR_INDEX, ADDR_DATA, ADDR_LINE_VOL};
  ////////////////////
  access_ready_a: assert property (acc |-> pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  idle_err_a: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  suppress_read_a: assert property (!isa_periph_rd |-> !isa_periph_drive_en)
    else $error("data bus driven without read");
  pin_zero_a: assert property (!$past(reset) |-> xd_drv.o[0] == $past(periph_drv.o[0])
    && xd_drv.oe[0] == $past(periph_drv.oe[0])) else $error("pin 0 not peripheral");
  load_done_a: assert property (ee_valid && ee_last && !cfg_loaded |=> cfg_loaded)
    else $error("load not finished");
  fw_decide_a: assert property ($rose(cfg_loaded) |=> fw_load_en != fw_ignore)
    else $error("code base not decided");
  fw_exclusive_a: assert property (!(fw_load_en && fw_ignore))
    else $error("firmware load and ignore both set");
  chip_id_a: assert property (ext_id == CHIP_ID)
    else $error("extended id wrong");
  ////////////////////
  cover property (acc && pslverr);
  cover property ($rose(fw_load_en));
  cover property ($rose(fw_ignore));
  cover property (isa_periph_rd && !isa_periph_drive_en);
endmodule // ccp_props

bind ccp_control ccp_props #(.CHIP_ID(CHIP_ID)) u_ccp_props (.clk(clk), .reset(reset),
  .apb_req(apb_req), .pready(pready), .pslverr(pslverr), .ee_valid(ee_valid),
  .ee_last(ee_last), .fw_load_en(fw_load_en), .fw_ignore(fw_ignore), .cfg_loaded(cfg_loaded),
  .isa_periph_rd(isa_periph_rd), .isa_periph_drive_en(isa_periph_drive_en),
  .periph_drv(periph_drv), .xd_drv(xd_drv), .ext_id(ext_id));

// *** verif/ccp_ee_model.sv ***
`timescale 1ns/1ns
module ccp_ee_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] gcfg,
  input wire logic [7:0] code,
  output logic ee_valid,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_data,
  output logic ee_last
);
  logic [3:0] idx_q;
  logic busy_q;
  logic gap_q;
  always @(posedge clk) begin
    ee_valid <= 1'b0;
    ee_last <= 1'b0;
    // Idle lines keep toggling so stale bytes never look valid
    ee_addr <= ~ee_addr;
    ee_data <= ~ee_data;
    gap_q <= ~gap_q;
    if (reset) begin
      {idx_q, busy_q, gap_q, ee_addr, ee_data} <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (busy_q && !(slow && gap_q)) begin
      ee_valid <= 1'b1;
      ee_addr <= {4'h0, idx_q};
      ee_data <= (idx_q == 4'h2) ? gcfg : (idx_q == 4'h9) ? code : {idx_q, ~idx_q};
      ee_last <= (idx_q == 4'h9);
      busy_q <= (idx_q != 4'h9);
      idx_q <= idx_q + 4'h1;
    end
  end
endmodule // ccp_ee_model

// *** verif/test_control_config_and_pin_mux.sv ***
`timescale 1ns/1ns
module test_control_config_and_pin_mux;
  import ccp_pkg::*;
  // Arbitrary chip id
  localparam logic [7:0] ID = 8'h3c;
  logic clk, reset, start, slow, rd, swr, er, fwl, fwi, cl, den, vu, vd, pready, pslverr;
  logic ee_valid, ee_last;
  logic [1:0] vp;
  logic [2:0] wrx;
  logic [3:0] js, drx;
  logic [7:0] g, code, sd, xi, lv, eid, ee_addr, ee_data;
  logic [31:0] r, prdata, nu, nd;
  ccp_apb_req_t req;
  ccp_pins8_t pd, xd;
  ccp_ser4_t sp, js2;
  ccp_ser3_t wp;
  int n_errors, compares, seed, cyc;
  ccp_control #(.CHIP_ID(ID)) u_ccp_control (.clk(clk), .reset(reset), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_valid(ee_valid),
    .ee_addr(ee_addr), .ee_data(ee_data), .ee_last(ee_last), .fw_load_en(fwl),
    .fw_ignore(fwi), .cfg_loaded(cl), .isa_periph_rd(rd), .isa_periph_drive_en(den),
    .xd_in(xi), .periph_drv(pd), .xd_drv(xd), .js2_in(js), .js2_drv(js2), .dsp_drv(sp),
    .dsp_rx(drx), .wt_drv(wp), .wt_rx(wrx), .vol_pins(vp), .vol_up(vu), .vol_down(vd),
    .synth_vol_wr(swr), .synth_vol_data(sd), .line_volume(lv), .ext_id(eid));
  ccp_ee_model u_ccp_ee_model (.clk(clk), .reset(reset), .start(start), .slow(slow),
    .gcfg(g), .code(code), .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data),
    .ee_last(ee_last));
  ////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task complete_run();
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  function automatic ccp_pins8_t exp_xd(input logic wt, input logic ds);
    exp_xd = pd;
    if (wt) {exp_xd.o[7:5], exp_xd.oe[7:5]} = {wp.o, wp.oe};
    if (ds) {exp_xd.o[4:1], exp_xd.oe[4:1]} = {sp.o, sp.oe};
  endfunction
  // Expected {up, down} for one pin change in each volume format
  function automatic logic [1:0] exp_vol(input logic [1:0] f, input logic [1:0] p,
                                         input logic [1:0] n);
    case (f)
      2'h0: exp_vol = {p[0] & ~n[0], p[1] & ~n[1]};
      2'h1: exp_vol = {~p[0] & n[0], ~p[1] & n[1]};
      2'h2: exp_vol = {2{~p[0] & n[0]}} & {n[1], ~n[1]};
      default: exp_vol = {2{p[0] ^ n[0]}} & {n[0] ^ n[1], ~(n[0] ^ n[1])};
    endcase
  endfunction
  always @(posedge clk) begin
    if (!reset) begin
      nu <= nu + 32'(vu);
      nd <= nd + 32'(vd);
    end
  end
  ////////////////////
  task run_code(input logic [7:0] c, input logic [7:0] am, input logic [7:0] om);
    logic [1:0] nv, pv;
    logic [7:0] ev;
    logic [31:0] eu, ed, u0, d0;
    g <= (8'($random(seed)) & am) | om;
    code <= c;
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    {reset, start} <= 2'b01;
    @(posedge clk);
    start <= 1'b0;
    repeat (60) if (cl !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("fw_load_en", 32'(c == CODE_BASE_CURRENT), 32'(fwl));
    chk("fw_ignore", 32'(c != CODE_BASE_CURRENT), 32'(fwi));
    apb(1'b0, ADDR_STATUS, 8'h00);
    chk("status", {21'h0, c != CODE_BASE_CURRENT, c == CODE_BASE_CURRENT, 1'b1, g}, r);
    rd <= 1'b1;
    repeat (2) @(posedge clk);
    chk("drive_en", 32'(!g[GCFG_SUPPRESS_BIT]), 32'(den));
    rd <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_INDEX, 8'(CIND_PINMUX));
      apb(1'b1, ADDR_DATA, 8'(k));
      {pd, wp, sp, xi, js, vp} <= {$random(seed), $random(seed)};
      repeat (2) @(posedge clk);
      chk("xd_drv", 32'(exp_xd(k[0] | g[GCFG_WT_BIT], k[1] | g[GCFG_DSP_BIT])), 32'(xd));
      chk("js2_drv", (k[1] | g[GCFG_DSP_BIT]) ? 32'h0 : 32'(sp), 32'(js2));
      repeat (2) @(posedge clk);
      chk("wt_rx", (k[0] | g[GCFG_WT_BIT]) ? 32'(xi[7:5]) : 32'h0, 32'(wrx));
      chk("dsp_rx", (k[1] | g[GCFG_DSP_BIT]) ? 32'(xi[4:1]) : 32'(js), 32'(drx));
      apb(1'b0, ADDR_DATA, 8'h00);
      chk("pinmux", 32'(k), r);
    end
    apb(1'b1, ADDR_INDEX, 8'(CIND_ID));
    apb(1'b1, ADDR_DATA, 8'hff);
    apb(1'b0, ADDR_DATA, 8'h00);
    chk("chip_id", 32'(ID), r);
    apb(1'b0, ADDR_INDEX, 8'h00);
    chk("index", 32'(CIND_ID), r);
    apb(1'b0, 12'h020, 8'h00);
    chk("unmapped", 32'h1, 32'(er));
    chk("unmapped_rd", 32'h0, r);
    apb(1'b1, ADDR_LINE_VOL, (8'h5a ^ g) & 8'hfe);
    {swr, sd} <= {1'b1, 8'($random(seed)) | 8'h01};
    @(posedge clk);
    swr <= 1'b0;
    @(posedge clk);
    ev = g[GCFG_DECOUPLE_BIT] ? (8'h5a ^ g) & 8'hfe : sd;
    chk("line_volume", 32'(ev), 32'(lv));
    apb(1'b0, ADDR_LINE_VOL, 8'h00);
    chk("line_read", 32'(ev), r);
    u0 = nu;
    d0 = nd;
    {eu, ed} = '0;
    for (int j = 0; j < 12; j++) begin
      nv = 2'($random(seed));
      pv = exp_vol({g[GCFG_VF_HI_BIT], g[GCFG_VF_LO_BIT]}, vp, nv);
      eu += 32'(pv[1]);
      ed += 32'(pv[0]);
      vp <= nv;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    chk("vol_up", eu, nu - u0);
    chk("vol_down", ed, nd - d0);
  endtask
  initial begin
    {seed, n_errors, compares, cyc} = {32'h2f70, 96'h0};
    {reset, start, slow, rd, swr, g, code, sd, xi, js, vp} = '1;
    {start, slow, rd, swr} = '0;
    {req, pd, wp, sp, nu, nd} = '0;
    run_code(CODE_BASE_CURRENT, 8'hc0, 8'h00);
    slow <= 1'b1;
    run_code(CODE_BASE_LEGACY, 8'hc0, 8'h37);
    run_code(8'($random(seed)), 8'he7, 8'h08);
    run_code(8'($random(seed)), 8'hff, 8'h18);
    chk("ext_id", 32'(ID), 32'(eid));
    complete_run();
  end
endmodule // test_control_config_and_pin_mux
